// file: inc/sfc_pkg.sv
// Types shared by the switch forwarding configuration block
package sfc_pkg;
	typedef enum logic {
		SFC_ORDER_FILL,
		SFC_ORDER_PINGPONG
	} sfc_order_e;
	// Forwarding verdict for one ingress frame
	typedef struct packed {
		logic port2;
		logic to_other;
		logic to_host;
		logic low_prio;
		logic passthrough;
		logic drop;
	} sfc_fwd_s;
	// Host read selection
	typedef struct packed {
		logic port2;
		logic high;
	} sfc_sel_s;
endpackage

// file: inc/sfc_regs.svh
// Register offsets, field positions and reset values of the forwarding config
`ifndef SFC_REGS_SVH
`define SFC_REGS_SVH
`define SFC_CFG2_ADDR 8'h06
`define SFC_CFG2_RESET 32'h0000_0800
`define SFC_CFG2_WMASK 32'h0001_ffd4
`define SFC_STAT_BASE 8'h80
`define SFC_B_P2_GAP 16
`define SFC_B_ORDER 15
`define SFC_B_P2_TO_P1 14
`define SFC_B_P1_TO_P2 13
`define SFC_B_P2_HOST 12
`define SFC_B_PASS 11
`define SFC_B_TX_EMPTY 8
`define SFC_B_SFD_SRC 7
`define SFC_B_CLR_RD 6
`define SFC_B_P1_GAP 4
`define SFC_B_P1_HOST 2
`endif

// file: logic/sfc_top.sv
// Switch forwarding configuration register, its decisions and a verdict FIFO
// What this block does
// RULE_01: Gap-error bit 16 set lets port 2 accept frames violating the gap.
// RULE_02: Read order 0 returns first the port holding most data at priority.
// RULE_03: Fill order serves high FIFOs first, fullest low only when highs empty.
// RULE_04: Read order 1 alternates ports, one frame from each in turn.
// RULE_05: Alternating order still returns every high frame before any low.
// RULE_06: Bit 14 forwards unknown port 2 frames to port 1.
// RULE_07: Bit 13 forwards unknown port 1 frames to port 2.
// RULE_08: Unknown frame dropped when its port and host forwarding bits are 0.
// RULE_09: Bit 12 sends unknown port 2 frames to host, low priority FIFO.
// RULE_10: Bit 11 enables port cut-through and resets to one.
// RULE_11: Host sets cut-through before any forwarding bit or filter write.
// RULE_12: Transmit ready marks a sent frame, or empty FIFO when bit 8 set.
// RULE_13: Bit 7 at 0 takes frame-start detection from the PHY domain.
// RULE_14: Bit 7 at 1 takes frame-start detection from the MAC domain.
// RULE_15: Bit 6 selects clear-on-read for all statistics counters.
// RULE_16: Without clear-on-read a read leaves counters; they wrap at maximum.
// RULE_17: With clear-on-read a read clears; counters saturate until read.
// RULE_18: Bit 2 sends unknown port 1 frames to host, low priority FIFO.
// RULE_19: Bit 4 set lets port 1 accept frames violating the gap.
// RULE_20: Bits 31 to 17 read zero; bits 10 and 9 just store.
`timescale 1ns/1ns
`include "sfc_regs.svh"

module sfc_fifo #(
	parameter int WIDTH = 6,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// Drain side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	// Full and empty come straight from the word count
	assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_out = (cnt_q != '0);
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	assign out_data_out = mem_q[rd_q];

	// Storage, written only on an accepted push
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_q[wr_q] <= in_data_in;
		end
	end

	// Pointers and count
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // sfc_fifo

module sfc_top #(
	parameter int FILL_W = 12,
	parameter int N_CNT = 4,
	parameter int CNT_W = 16,
	parameter int FIFO_DEPTH = 16
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Register port
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	output logic [31:0] reg_rdata_out,
	// Ingress frame verdict request
	input wire logic frm_valid_in,
	output logic frm_ready_out,
	input wire logic frm_port2_in,
	input wire logic frm_matched_in,
	// Verdict stream out
	output logic fwd_valid_out,
	input wire logic fwd_ready_in,
	output sfc_pkg::sfc_fwd_s fwd_out,
	// Inter-frame gap check, index 0 is port 1
	input wire logic [1:0] gap_error_in,
	output logic [1:0] gap_admit_out,
	// Host read order
	input wire logic [FILL_W-1:0] fill_p1_hi_in,
	input wire logic [FILL_W-1:0] fill_p1_lo_in,
	input wire logic [FILL_W-1:0] fill_p2_hi_in,
	input wire logic [FILL_W-1:0] fill_p2_lo_in,
	input wire logic sel_req_in,
	output logic sel_valid_out,
	output sfc_pkg::sfc_sel_s sel_out,
	// Transmit ready indication
	input wire logic tx_sent_in,
	input wire logic tx_empty_in,
	output logic tx_ready_out,
	// Frame-start detection
	input wire logic sfd_phy_in,
	input wire logic sfd_mac_in,
	output logic sfd_out,
	// Statistics counter events
	input wire logic [N_CNT-1:0] cnt_inc_in
);
	logic [31:0] cfg_q;
	logic [31:0] rdata_d;
	logic [31:0] rdata_q;
	logic [CNT_W-1:0] cnt_q [N_CNT];
	logic port2_last_q;
	logic sel_valid_q;
	sfc_pkg::sfc_sel_s sel_q;
	sfc_pkg::sfc_sel_s sel_d;
	logic sel_any;
	sfc_pkg::sfc_fwd_s verdict;
	logic tx_ready_q;
	logic sfd_q;
	logic [1:0] gap_admit_q;
	logic cfg_wr;
	logic any_hi;
	logic any_lo;
	logic p1_has;
	logic p2_has;

	assign cfg_wr = reg_wr_in && (reg_addr_in == `SFC_CFG2_ADDR);

	// Config register; masked bits stay zero so reserved reads return zero
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_q <= `SFC_CFG2_RESET; // RULE_10
		end else if (cfg_wr) begin
			cfg_q <= reg_wdata_in & `SFC_CFG2_WMASK; // RULE_20
		end
	end

	// Read mux, answer one cycle after the read strobe
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (reg_addr_in == `SFC_CFG2_ADDR) begin
			rdata_d = cfg_q;
		end
		for (int i = 0; i < N_CNT; i++) begin
			if (reg_addr_in == `SFC_STAT_BASE + 8'(i)) begin
				rdata_d = 32'(cnt_q[i]);
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_q <= 32'h0000_0000;
		end else if (reg_rd_in) begin
			rdata_q <= rdata_d;
		end
	end
	assign reg_rdata_out = rdata_q;

	// Statistics counters; an event in the clearing read's cycle still counts
	for (genvar g = 0; g < N_CNT; g++) begin : g_cnt
		logic hit;
		assign hit = reg_rd_in && (reg_addr_in == `SFC_STAT_BASE + 8'(g));
		always_ff @(posedge clk_in or posedge rst_in) begin
			if (rst_in) begin
				cnt_q[g] <= '0;
			end else if (cfg_q[`SFC_B_CLR_RD]) begin // RULE_15
				if (hit) begin
					cnt_q[g] <= CNT_W'(cnt_inc_in[g]); // RULE_17
				end else if (cnt_inc_in[g] && cnt_q[g] != '1) begin
					cnt_q[g] <= cnt_q[g] + 1'b1; // RULE_17
				end
			end else if (cnt_inc_in[g]) begin
				cnt_q[g] <= cnt_q[g] + 1'b1; // RULE_16
			end
		end
	end

	// Forwarding verdict, built from the ingress port's bits
	always_comb begin
		verdict = '0;
		verdict.port2 = frm_port2_in;
		verdict.passthrough = cfg_q[`SFC_B_PASS]; // RULE_10
		if (frm_matched_in) begin
			verdict.to_host = 1'b1;
		end else if (frm_port2_in) begin
			verdict.to_other = cfg_q[`SFC_B_P2_TO_P1]; // RULE_06
			verdict.to_host = cfg_q[`SFC_B_P2_HOST]; // RULE_09
			verdict.low_prio = cfg_q[`SFC_B_P2_HOST]; // RULE_09
		end else begin
			verdict.to_other = cfg_q[`SFC_B_P1_TO_P2]; // RULE_07
			verdict.to_host = cfg_q[`SFC_B_P1_HOST]; // RULE_18
			verdict.low_prio = cfg_q[`SFC_B_P1_HOST]; // RULE_18
		end
		verdict.drop = !verdict.to_other && !verdict.to_host; // RULE_08
	end

	// Verdicts queue so a slow forwarding engine back-pressures ingress
	sfc_fifo #(
		.WIDTH($bits(sfc_pkg::sfc_fwd_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.in_valid_in(frm_valid_in),
		.in_ready_out(frm_ready_out),
		.in_data_in(verdict),
		.out_valid_out(fwd_valid_out),
		.out_ready_in(fwd_ready_in),
		.out_data_out(fwd_out)
	);

	// Read-order choice; high priority always wins over low
	assign p1_has = any_hi ? (fill_p1_hi_in != '0) : (fill_p1_lo_in != '0);
	assign p2_has = any_hi ? (fill_p2_hi_in != '0) : (fill_p2_lo_in != '0);
	assign any_hi = (fill_p1_hi_in != '0) || (fill_p2_hi_in != '0);
	assign any_lo = (fill_p1_lo_in != '0) || (fill_p2_lo_in != '0);
	assign sel_any = any_hi || any_lo;
	always_comb begin
		sel_d.high = any_hi; // RULE_03 RULE_05
		if (cfg_q[`SFC_B_ORDER] == sfc_pkg::SFC_ORDER_PINGPONG) begin
			// Take the other port when it has a frame at this level
			sel_d.port2 = (p1_has && p2_has) ? !port2_last_q : p2_has; // RULE_04
		end else if (any_hi) begin
			sel_d.port2 = fill_p2_hi_in > fill_p1_hi_in; // RULE_02
		end else begin
			sel_d.port2 = fill_p2_lo_in > fill_p1_lo_in; // RULE_02 RULE_03
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sel_valid_q <= 1'b0;
			sel_q <= '0;
			port2_last_q <= 1'b1;
		end else begin
			sel_valid_q <= sel_req_in && sel_any;
			if (sel_req_in && sel_any) begin
				sel_q <= sel_d;
				port2_last_q <= sel_d.port2; // RULE_04
			end
		end
	end
	assign sel_valid_out = sel_valid_q;
	assign sel_out = sel_q;

	// Gap admit, transmit ready and frame-start source, registered
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			gap_admit_q <= 2'b00;
			tx_ready_q <= 1'b0;
			sfd_q <= 1'b0;
		end else begin
			gap_admit_q[0] <= !gap_error_in[0] || cfg_q[`SFC_B_P1_GAP]; // RULE_19
			gap_admit_q[1] <= !gap_error_in[1] || cfg_q[`SFC_B_P2_GAP]; // RULE_01
			tx_ready_q <= cfg_q[`SFC_B_TX_EMPTY] ? tx_empty_in
				: tx_sent_in; // RULE_12
			// The PHY source carries less jitter, hence the reset choice
			sfd_q <= cfg_q[`SFC_B_SFD_SRC] ? sfd_mac_in // RULE_14
				: sfd_phy_in; // RULE_13
		end
	end
	assign gap_admit_out = gap_admit_q;
	assign tx_ready_out = tx_ready_q;
	assign sfd_out = sfd_q;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	a_reserved_zero: assert property (cfg_q[31:17] == '0) // RULE_20
		else $error("reserved config bits not zero");
	a_p2_gap_admit: assert property (gap_error_in[1] && cfg_q[16] // RULE_01
		|=> gap_admit_out[1]) else $error("port 2 gap frame refused");
	a_p1_gap_refuse: assert property (gap_error_in[0] && !cfg_q[4] // RULE_19
		|=> !gap_admit_out[0]) else $error("port 1 gap frame admitted");
	a_drop_rule: assert property (frm_valid_in && !frm_matched_in // RULE_08
		&& !frm_port2_in && !cfg_q[13] && !cfg_q[2] |-> verdict.drop)
		else $error("unknown frame not dropped");
	a_p2_host_low: assert property (!frm_matched_in && frm_port2_in // RULE_09
		&& cfg_q[12] |-> verdict.to_host && verdict.low_prio)
		else $error("port 2 unknown not sent low");
	a_fill_high_first: assert property (sel_req_in && any_hi // RULE_03
		|=> sel_valid_out && sel_out.high) else $error("low served first");
	a_fill_most: assert property (sel_req_in && !cfg_q[15] // RULE_02
		&& fill_p2_hi_in > fill_p1_hi_in |=> sel_out.port2)
		else $error("fuller port not chosen");
	a_ping_alt: assert property (sel_req_in && cfg_q[15] && p1_has // RULE_04
		&& p2_has |=> sel_out.port2 != $past(port2_last_q))
		else $error("ports did not alternate");
	a_tx_empty: assert property (cfg_q[8] |=> tx_ready_out // RULE_12
		== $past(tx_empty_in)) else $error("tx ready ignores empty mode");
	a_sfd_src: assert property (!cfg_q[7] |=> sfd_out // RULE_13
		== $past(sfd_phy_in)) else $error("frame start not from PHY");
	a_cnt_wrap: assert property (!cfg_q[6] && cnt_inc_in[0] // RULE_16
		&& cnt_q[0] == '1 |=> cnt_q[0] == '0) else $error("no wrap");
	a_cnt_sat: assert property (cfg_q[6] && cnt_q[0] == '1 && !(reg_rd_in // RULE_17
		&& reg_addr_in == `SFC_STAT_BASE) |=> cnt_q[0] == '1)
		else $error("counter left saturation");

	c_ping: cover property (sel_valid_out && cfg_q[15] ##1 sel_valid_out);
	c_drop: cover property (fwd_valid_out && fwd_out.drop);
	c_fifo_full: cover property (!frm_ready_out);
endmodule // sfc_top

// file: sim/sfc_host_model.sv
// Host register access model driving the forwarding config register port
`timescale 1ns/1ns
module sfc_host_model (
	// Clock
	input wire logic clk_in,
	// Register port
	output logic reg_wr_out,
	output logic reg_rd_out,
	output logic [7:0] reg_addr_out,
	output logic [31:0] reg_wdata_out,
	input wire logic [31:0] reg_rdata_in
);
	// Idle bus, address and data parked at a value nobody should decode
	initial begin
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
		reg_addr_out = 8'hff;
		reg_wdata_out = 32'h0000_0000;
	end
	// One write; cut-through stays on so it precedes any forwarding setup
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk_in);
		reg_wr_out = 1'b1;
		reg_addr_out = a;
		reg_wdata_out = d | 32'h0000_0800;
		@(negedge clk_in);
		reg_wr_out = 1'b0;
		reg_addr_out = ~a;
		reg_wdata_out = ~reg_wdata_out;
	endtask
	// One read; data is registered so it is settled one edge later
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(negedge clk_in);
		reg_rd_out = 1'b1;
		reg_addr_out = a;
		@(negedge clk_in);
		reg_rd_out = 1'b0;
		reg_addr_out = ~a;
		d = reg_rdata_in;
	endtask
endmodule // sfc_host_model

// file: sim/tb.sv
// Self-checking bench of the switch forwarding configuration block
`timescale 1ns/1ns
`include "sfc_regs.svh"
module tb;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic reg_wr, reg_rd;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, r;
	logic frm_valid = 1'b0, frm_ready, frm_port2 = 1'b0, frm_match = 1'b0;
	logic fwd_valid, fwd_ready = 1'b0;
	sfc_pkg::sfc_fwd_s fwd;
	logic [1:0] gap_err = 2'h0, gap_adm;
	logic [11:0] f1h = '0, f1l = '0, f2h = '0, f2l = '0;
	logic sel_req = 1'b0, sel_valid, tx_sent = 1'b0, tx_empty = 1'b0;
	sfc_pkg::sfc_sel_s sel, s0;
	logic tx_rdy, sfd_phy = 1'b0, sfd_mac = 1'b0, sfd;
	logic [3:0] cnt_inc = 4'h0;
	int n_fail = 0, num_checks = 0;
	// Free-running 100 MHz clock
	always #5 clk_in = ~clk_in;
	// Narrow counters so the wrap and saturation points are reachable
	sfc_top #(.CNT_W(4)) u_sfc_top (.clk_in(clk_in), .rst_in(rst_in),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_addr_in(reg_addr),
		.reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
		.frm_valid_in(frm_valid), .frm_ready_out(frm_ready),
		.frm_port2_in(frm_port2), .frm_matched_in(frm_match),
		.fwd_valid_out(fwd_valid), .fwd_ready_in(fwd_ready), .fwd_out(fwd),
		.gap_error_in(gap_err), .gap_admit_out(gap_adm),
		.fill_p1_hi_in(f1h), .fill_p1_lo_in(f1l), .fill_p2_hi_in(f2h),
		.fill_p2_lo_in(f2l), .sel_req_in(sel_req), .sel_valid_out(sel_valid),
		.sel_out(sel), .tx_sent_in(tx_sent), .tx_empty_in(tx_empty),
		.tx_ready_out(tx_rdy), .sfd_phy_in(sfd_phy), .sfd_mac_in(sfd_mac),
		.sfd_out(sfd), .cnt_inc_in(cnt_inc));
	sfc_host_model u_sfc_host_model (.clk_in(clk_in), .reg_wr_out(reg_wr),
		.reg_rd_out(reg_rd), .reg_addr_out(reg_addr),
		.reg_wdata_out(reg_wdata), .reg_rdata_in(reg_rdata));
	// Verdict and closing
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Reset value, write mask, unmapped read
	task automatic t_regs();
		u_sfc_host_model.rd(`SFC_CFG2_ADDR, r);
		chk(r, `SFC_CFG2_RESET);
		u_sfc_host_model.wr(`SFC_CFG2_ADDR, 32'hffff_ffff);
		u_sfc_host_model.rd(`SFC_CFG2_ADDR, r);
		chk(r, `SFC_CFG2_WMASK);
		u_sfc_host_model.rd(8'h40, r);
		chk(r, 32'h0000_0000);
		$display("test regs done");
	endtask
	// Verdicts; low_prio ignored on drops; bit 6 of ex marks a matched frame
	task automatic t_fwd();
		logic [31:0] cf [7] = '{32'h4000, 32'h1000, 32'h2000, 32'h4,
			32'h2000, 0, 0};
		logic [6:0] ex [7] = '{7'h32, 7'h2e, 7'h12, 7'h0e, 7'h23, 7'h03,
			7'h4a};
		logic [5:0] m;
		for (int i = 0; i < 7; i++) begin
			u_sfc_host_model.wr(`SFC_CFG2_ADDR, cf[i]);
			frm_valid = 1'b1;
			frm_port2 = ex[i][5];
			frm_match = ex[i][6];
			@(negedge clk_in);
			frm_valid = 1'b0;
			frm_port2 = ~ex[i][5];
			frm_match = 1'b0;
			for (int k = 0; k < 8 && fwd_valid !== 1'b1; k++)
				@(negedge clk_in);
			// A verdict that never shows is a hang: count it and stop here
			if (fwd_valid !== 1'b1) begin
				chk(32'(fwd_valid), 32'h0000_0001);
				final_report();
			end
			m = ex[i][0] ? 6'h3b : 6'h3f;
			chk(32'(fwd & m), 32'(ex[i][5:0]));
			fwd_ready = 1'b1;
			@(negedge clk_in);
			fwd_ready = 1'b0;
		end
		$display("test fwd done");
	endtask
	// Fill the verdict FIFO with the drain stalled, then empty it
	task automatic t_fifo();
		int n;
		n = 0;
		frm_valid = 1'b1;
		while (frm_ready === 1'b1 && n < 20) begin
			@(negedge clk_in);
			n++;
		end
		frm_valid = 1'b0;
		chk(32'(n), 32'h0000_0010);
		if (n == 20)
			final_report();
		n = 0;
		fwd_ready = 1'b1;
		while (fwd_valid === 1'b1 && n < 20) begin
			@(negedge clk_in);
			n++;
		end
		fwd_ready = 1'b0;
		chk(32'(n), 32'h0000_0010);
		if (n == 20)
			final_report();
		$display("test fifo done");
	endtask
	// Gap admit, transmit ready and frame-start source, {gap,sent,empty,phy,mac}
	task automatic t_misc();
		logic [31:0] cf [4] = '{0, 32'h0001_0180, 32'h0190, 0};
		logic [5:0] in [4] = '{6'h3a, 6'h3a, 6'h35, 6'h35};
		logic [3:0] ex [4] = '{4'h3, 4'h8, 4'h7, 4'h0};
		for (int i = 0; i < 4; i++) begin
			u_sfc_host_model.wr(`SFC_CFG2_ADDR, cf[i]);
			{gap_err, tx_sent, tx_empty, sfd_phy, sfd_mac} = in[i];
			repeat (2) @(negedge clk_in);
			chk(32'({gap_adm, tx_rdy, sfd}), 32'(ex[i]));
		end
		$display("test misc done");
	endtask
	// One pick request; a pulse must follow unless all fills are empty
	task automatic pick(input logic [11:0] a, b, c, d, input logic v);
		// Let an edge pass so back-to-back picks never re-raise in one step
		@(negedge clk_in);
		{f1h, f1l, f2h, f2l} = {a, b, c, d};
		sel_req = 1'b1;
		@(negedge clk_in);
		sel_req = 1'b0;
		chk(32'(sel_valid), 32'(v));
	endtask
	task automatic t_sel();
		u_sfc_host_model.wr(`SFC_CFG2_ADDR, 0);
		pick(12'h3, 12'h9, 12'h5, 12'h0, 1'b1);
		chk(32'(sel), 32'h3);
		pick(12'h0, 12'h7, 12'h0, 12'h2, 1'b1);
		chk(32'(sel), 32'h0);
		pick(12'h0, 12'h0, 12'h0, 12'h0, 1'b0);
		u_sfc_host_model.wr(`SFC_CFG2_ADDR, 32'h8000);
		pick(12'h2, 12'h0, 12'h2, 12'h0, 1'b1);
		s0 = sel;
		pick(12'h2, 12'h0, 12'h2, 12'h0, 1'b1);
		chk(32'(sel), 32'({~s0.port2, 1'b1}));
		pick(12'h0, 12'h9, 12'h4, 12'h0, 1'b1);
		chk(32'(sel), 32'h3);
		$display("test sel done");
	endtask
	// Counter 0: wrap without clear-on-read, clear and saturate with it
	task automatic inc(input int n);
		cnt_inc = 4'h1;
		repeat (n) @(negedge clk_in);
		cnt_inc = 4'h0;
	endtask
	task automatic t_cnt();
		u_sfc_host_model.wr(`SFC_CFG2_ADDR, 0);
		inc(3);
		u_sfc_host_model.rd(`SFC_STAT_BASE, r);
		u_sfc_host_model.rd(`SFC_STAT_BASE, r);
		chk(r, 32'h3);
		inc(14);
		u_sfc_host_model.rd(`SFC_STAT_BASE, r);
		chk(r, 32'h1);
		u_sfc_host_model.wr(`SFC_CFG2_ADDR, 32'h40);
		u_sfc_host_model.rd(`SFC_STAT_BASE, r);
		u_sfc_host_model.rd(`SFC_STAT_BASE, r);
		chk(r, 32'h0);
		inc(20);
		u_sfc_host_model.rd(`SFC_STAT_BASE, r);
		chk(r, 32'hf);
		$display("test cnt done");
	endtask
	// Main sequence after a 12-cycle reset
	initial begin
		repeat (12) @(negedge clk_in);
		rst_in = 1'b0;
		t_regs();
		t_fwd();
		t_fifo();
		t_misc();
		t_sel();
		t_cnt();
		final_report();
	end
endmodule // tb
